// [cmd_frame_and_conv_poll.sv]
// Purpose: Command frame decoder and conversion status polling front end.
// Assumes: link_clk is the serial clock, data sampled on its rising edge.
// Notes: Framing logic is cleared while chip select is high.
`timescale 1ns/1ps
module cmd_frame_and_conv_poll #(
  parameter int DBYTES = cmd_frame_pkg::DATA_BYTES
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   link_clk,
  input  wire logic                   chip_select_n,
  input  wire logic                   serial_in_line,
  input  wire logic                   iface_mode_pin,
  input  wire logic                   chain_variant_pin,
  input  wire logic                   addr_strap_bit3,
  input  wire logic                   addr_strap_bit2,
  input  wire logic                   addr_strap_bit1,
  input  wire logic                   addr_strap_bit0,
  input  wire logic                   conv_busy,
  output logic                        serial_out_line,
  output logic                        pulse_reply,
  output logic                        cmd_strobe,
  output logic [cmd_frame_pkg::OP_W-1:0] cmd_op_code,
  output logic                        conv_start,
  output logic                        poll_active,
  output logic                        block_ok,
  output logic [8*DBYTES-1:0]         block_data
);
  import cmd_frame_pkg::*;

  function automatic logic is_conv(input logic [OP_W-1:0] op);
    is_conv = (op[OP_MSB -: 2] == OP_CONV_CV) || (op[OP_MSB -: 2] == OP_CONV_AX);
  endfunction

  function automatic logic is_poll(input logic [OP_W-1:0] op);
    is_poll = (op == OP_POLL) || (op == OP_DIAG);
  endfunction

  // Link domain: framing is held in reset while chip select is high.
  wire link_rst = rst | chip_select_n;

  link_state_t           state_reg;
  link_state_t           state_next;
  logic [2:0]            bit_cnt_reg;
  logic [3:0]            byte_cnt_reg;
  logic [3:0]            byte_cnt_next;
  logic                  first_reg;
  logic [CMD_W-1:0]      cmd_sh_reg;
  logic [CMD_W-1:0]      rx_crc_reg;
  logic [8*DBYTES-1:0]   data_sh_reg;
  logic [CRC_W-1:0]      crc_val;
  logic                  cmd_tgl_reg;
  logic                  blk_tgl_reg;
  logic [CMD_W-1:0]      cmd_hold_reg;
  logic [8*DBYTES-1:0]   data_hold_reg;
  logic                  reply_s1_reg;
  logic                  reply_s2_reg;
  logic                  reply_reg;
  logic                  reply_en_reg;

  wire byte_end  = (bit_cnt_reg == 3'h7);
  wire in_crc_st = (state_reg == LNK_CCRC) || (state_reg == LNK_DCRC);
  wire crc_en    = (state_reg == LNK_CMD) || (state_reg == LNK_DATA);
  wire [CMD_W-1:0] rx_crc_now = {rx_crc_reg[CMD_W-2:0], serial_in_line};
  wire crc_match = (rx_crc_now == {crc_val, 1'b0});
  wire seg_end   = byte_end && (byte_cnt_next == ((state_reg == LNK_DATA) ?
                   4'(DBYTES) : (in_crc_st ? CRC_BYTES : CMD_BYTES)));
  wire cmd_good  = (state_reg == LNK_CCRC) && seg_end && crc_match;
  wire blk_good  = (state_reg == LNK_DCRC) && seg_end && crc_match;

  assign byte_cnt_next = byte_cnt_reg + 4'h1;

  pec_serial u_pec (
    .clk     (link_clk),
    .rst     (link_rst),
    .en      (crc_en),
    .restart (first_reg),
    .bit_in  (serial_in_line),
    .crc     (crc_val)
  );

  // Segment sequencing: command, its CRC, data block, data CRC, then ignored.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      LNK_CMD:  if (seg_end) state_next = LNK_CCRC;
      LNK_CCRC: if (seg_end) state_next = crc_match ? LNK_DATA : LNK_DROP;
      LNK_DATA: if (seg_end) state_next = LNK_DCRC;
      LNK_DCRC: if (seg_end) state_next = LNK_DROP;
      LNK_DROP: state_next = LNK_DROP;
      default:  state_next = LNK_DROP;
    endcase
  end

  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      state_reg    <= LNK_CMD;
      bit_cnt_reg  <= 3'h0;
      byte_cnt_reg <= 4'h0;
      first_reg    <= 1'b1;
    end else begin
      state_reg    <= state_next;
      bit_cnt_reg  <= bit_cnt_reg + 3'h1;
      first_reg    <= seg_end && (state_reg == LNK_CCRC);
      if (seg_end) begin
        byte_cnt_reg <= 4'h0;
      end else if (byte_end) begin
        byte_cnt_reg <= byte_cnt_next;
      end
    end
  end

  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      cmd_sh_reg  <= '0;
      rx_crc_reg  <= '0;
      data_sh_reg <= '0;
    end else begin
      if (state_reg == LNK_CMD) begin
        cmd_sh_reg <= {cmd_sh_reg[CMD_W-2:0], serial_in_line};
      end
      if (in_crc_st) begin
        rx_crc_reg <= rx_crc_now;
      end
      if (state_reg == LNK_DATA) begin
        data_sh_reg <= {data_sh_reg[8*DBYTES-2:0], serial_in_line};
      end
    end
  end

  // Event toggles and held words survive chip select so the crossing stays sound.
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      cmd_tgl_reg   <= 1'b0;
      blk_tgl_reg   <= 1'b0;
      cmd_hold_reg  <= '0;
      data_hold_reg <= '0;
    end else begin
      if (cmd_good) begin
        cmd_tgl_reg  <= ~cmd_tgl_reg;
        cmd_hold_reg <= cmd_sh_reg;
      end
      if (blk_good) begin
        blk_tgl_reg   <= ~blk_tgl_reg;
        data_hold_reg <= data_sh_reg;
      end
    end
  end

  // Reply level moves only on a master pulse edge and clears with chip select.
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      reply_s1_reg <= 1'b0;
      reply_s2_reg <= 1'b0;
      reply_reg    <= 1'b0;
    end else begin
      reply_s1_reg <= reply_en_reg;
      reply_s2_reg <= reply_s1_reg;
      reply_reg    <= reply_s2_reg;
    end
  end

  assign pulse_reply = reply_reg;

  // System domain: pin and event synchronisers.
  logic [2:0] cs_sync_reg;
  logic [2:0] iso_sync_reg;
  logic [2:0] chain_sync_reg;
  logic [2:0] ctgl_sync_reg;
  logic [2:0] btgl_sync_reg;
  logic [3:0] addr_s1_reg;
  logic [3:0] addr_s2_reg;
  logic [3:0] addr_s3_reg;
  logic       iso_q_reg;
  logic       chain_q_reg;
  logic [3:0] addr_q_reg;
  logic       cs_high_reg;
  logic       poll_reg;
  logic       poll_next;
  logic       sdo_reg;
  logic       strobe_reg;
  logic       start_reg;
  logic       blk_ok_reg;
  logic [OP_W-1:0]     op_reg;
  logic [8*DBYTES-1:0] blk_data_reg;

  wire [3:0] addr_pins = {addr_strap_bit3, addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_sync_reg    <= 3'h7;
      iso_sync_reg   <= 3'h0;
      chain_sync_reg <= 3'h0;
      ctgl_sync_reg  <= 3'h0;
      btgl_sync_reg  <= 3'h0;
      addr_s1_reg    <= 4'h0;
      addr_s2_reg    <= 4'h0;
      addr_s3_reg    <= 4'h0;
    end else begin
      cs_sync_reg    <= {cs_sync_reg[1:0], chip_select_n};
      iso_sync_reg   <= {iso_sync_reg[1:0], iface_mode_pin};
      chain_sync_reg <= {chain_sync_reg[1:0], chain_variant_pin};
      ctgl_sync_reg  <= {ctgl_sync_reg[1:0], cmd_tgl_reg};
      btgl_sync_reg  <= {btgl_sync_reg[1:0], blk_tgl_reg};
      addr_s1_reg    <= addr_pins;
      addr_s2_reg    <= addr_s1_reg;
      addr_s3_reg    <= addr_s2_reg;
    end
  end

  // A pin level is taken once the second and third stages agree.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      iso_q_reg   <= 1'b0;
      chain_q_reg <= 1'b0;
      addr_q_reg  <= 4'h0;
      cs_high_reg <= 1'b1;
    end else begin
      if (iso_sync_reg[1] == iso_sync_reg[2]) iso_q_reg <= iso_sync_reg[2];
      if (chain_sync_reg[1] == chain_sync_reg[2]) chain_q_reg <= chain_sync_reg[2];
      if (addr_s2_reg == addr_s3_reg) addr_q_reg <= addr_s3_reg;
      if (cs_sync_reg[1] == cs_sync_reg[2]) cs_high_reg <= cs_sync_reg[2];
    end
  end

  // Command decode in the system domain.
  wire             cmd_evt   = ctgl_sync_reg[1] ^ ctgl_sync_reg[2];
  wire             blk_evt   = btgl_sync_reg[1] ^ btgl_sync_reg[2];
  wire [OP_W-1:0]  dec_op    = cmd_hold_reg[OP_MSB:0];
  wire             dec_bcast = (cmd_hold_reg[BCAST_MSB:BCAST_LSB] == 5'h00);
  wire             dec_addr  = cmd_hold_reg[ADDR_FLAG] &&
                               (cmd_hold_reg[ADDR_MSB:ADDR_LSB] == addr_q_reg);
  wire             accept    = dec_bcast || (dec_addr && !chain_q_reg);
  wire             pollable  = is_conv(dec_op) || is_poll(dec_op);
  wire             poll_ok   = !chain_q_reg && !(iso_q_reg && dec_bcast);
  wire             poll_set  = cmd_evt && accept && pollable && poll_ok && !cs_high_reg;

  always_comb begin
    poll_next = poll_reg;
    if (cs_high_reg) begin
      poll_next = 1'b0;
    end
    if (poll_set) begin
      poll_next = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      poll_reg     <= 1'b0;
      sdo_reg      <= 1'b1;
      reply_en_reg <= 1'b0;
    end else begin
      poll_reg     <= poll_next;
      sdo_reg      <= !(poll_reg && conv_busy && !iso_q_reg);
      reply_en_reg <= poll_reg && conv_busy && iso_q_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strobe_reg   <= 1'b0;
      start_reg    <= 1'b0;
      blk_ok_reg   <= 1'b0;
      op_reg       <= '0;
      blk_data_reg <= '0;
    end else begin
      strobe_reg <= cmd_evt && accept;
      start_reg  <= cmd_evt && accept && is_conv(dec_op);
      blk_ok_reg <= blk_evt;
      if (cmd_evt && accept) op_reg <= dec_op;
      if (blk_evt) blk_data_reg <= data_hold_reg;
    end
  end

  assign serial_out_line = sdo_reg | chip_select_n;
  assign cmd_strobe      = strobe_reg;
  assign conv_start      = start_reg;
  assign cmd_op_code     = op_reg;
  assign poll_active     = poll_reg;
  assign block_ok        = blk_ok_reg;
  assign block_data      = blk_data_reg;

  sdo_cs_high_a: assert property (@(posedge clk) disable iff (rst)
    chip_select_n |-> serial_out_line)
    else $error("serial output not high with chip select high");

  sdo_busy_a: assert property (@(posedge clk) disable iff (rst)
    poll_reg && conv_busy && !iso_q_reg |=> !sdo_reg)
    else $error("serial output not low while polling busy");

  sdo_release_a: assert property (@(posedge clk) disable iff (rst)
    !conv_busy |=> sdo_reg)
    else $error("serial output not released after conversions");

  chain_no_poll_a: assert property (@(posedge clk) disable iff (rst)
    chain_q_reg && !poll_reg |=> !poll_reg)
    else $error("polling entered in chained variant");

  poll_exit_a: assert property (@(posedge clk) disable iff (rst)
    cs_high_reg && !poll_set |=> !poll_reg)
    else $error("polling kept after chip select high");

  addr_reject_a: assert property (@(posedge clk) disable iff (rst)
    cmd_evt && !accept |=> !cmd_strobe && !conv_start)
    else $error("command taken with foreign address");

  conv_go_a: assert property (@(posedge clk) disable iff (rst)
    cmd_evt && accept && is_conv(dec_op) |=> conv_start && cmd_op_code == $past(dec_op))
    else $error("conversion start or op code missing");

  iso_bcast_a: assert property (@(posedge clk) disable iff (rst)
    cmd_evt && iso_q_reg && dec_bcast && !poll_reg |=> !poll_reg)
    else $error("broadcast poll entered in isolated mode");

  crc_drop_a: assert property (@(posedge link_clk) disable iff (link_rst)
    (state_reg == LNK_CCRC) && seg_end && !crc_match |=> $stable(cmd_tgl_reg)
      && state_reg == LNK_DROP)
    else $error("command with bad CRC accepted");

  // A good command CRC hands the command word to the system side.
  cmd_crc_a: assert property (@(posedge link_clk) disable iff (link_rst)
    (state_reg == LNK_CCRC) && seg_end && crc_match |=> !$stable(cmd_tgl_reg))
    else $error("command with good CRC not passed on");

  reply_follow_a: assert property (@(posedge link_clk) disable iff (link_rst)
    reply_s2_reg |=> pulse_reply)
    else $error("no reply pulse while busy");

  // Broadcast commands are always taken; matching addressed commands are taken unless in the chained variant.
  bcast_take_a: assert property (@(posedge clk) disable iff (rst)
    cmd_evt && dec_bcast |=> cmd_strobe && cmd_op_code == $past(dec_op))
    else $error("broadcast command not taken");

  addr_take_a: assert property (@(posedge clk) disable iff (rst)
    cmd_evt && dec_addr && !chain_q_reg |=> cmd_strobe)
    else $error("command for this address not taken");

  block_take_a: assert property (@(posedge clk) disable iff (rst)
    blk_evt |=> block_ok && block_data == $past(data_hold_reg))
    else $error("data block not delivered");

  strobe_once_a: assert property (@(posedge clk) disable iff (rst)
    cmd_strobe |=> !cmd_strobe)
    else $error("command strobe longer than one cycle");
endmodule

// [cmd_frame_pkg.sv]
// Purpose: Constants for the command frame front end and conversion poll logic.
// Assumes: Mode 0 serial framing, most significant bit first, 15-bit packet CRC.
package cmd_frame_pkg;
  localparam int          CRC_W        = 15;
  localparam logic [14:0] CRC_SEED     = 15'h0010;
  localparam logic [14:0] CRC_POLY     = 15'h4599;
  localparam int          CMD_W        = 16;
  localparam int          OP_W         = 11;
  localparam int          OP_MSB       = 10;
  localparam int          ADDR_FLAG    = 15;
  localparam int          ADDR_MSB     = 14;
  localparam int          ADDR_LSB     = 11;
  localparam int          BCAST_MSB    = 15;
  localparam int          BCAST_LSB    = 11;
  localparam logic [3:0]  CMD_BYTES    = 4'h2;
  localparam logic [3:0]  CRC_BYTES    = 4'h2;
  localparam int          DATA_BYTES   = 6;
  localparam logic [10:0] OP_POLL      = 11'h714;
  localparam logic [10:0] OP_DIAG      = 11'h715;
  localparam logic [1:0]  OP_CONV_CV   = 2'h1;
  localparam logic [1:0]  OP_CONV_AX   = 2'h2;

  typedef enum logic [2:0] {
    LNK_CMD   = 3'h0,
    LNK_CCRC  = 3'h1,
    LNK_DATA  = 3'h3,
    LNK_DCRC  = 3'h2,
    LNK_DROP  = 3'h6
  } link_state_t;
endpackage

// [host_link_model.sv]
// Purpose: Host master model that drives command frames and poll pulses.
// Assumes: Mode 0 framing, 32 ns link clock that stands still outside frames.
// Notes: An idle data line shows the inverse of its last bit.
`timescale 1ns/1ps
module host_link_model (
  output logic link_clk,
  output logic chip_select_n,
  output logic serial_in_line
);
  import cmd_frame_pkg::*;
  logic [14:0] crc_reg;
  initial begin
    link_clk = 1'b0;
    chip_select_n = 1'b1;
    serial_in_line = 1'b1;
    crc_reg = CRC_SEED;
  end
  task automatic send_raw(input logic [63:0] v, input int n);
    logic fb;
    for (int i = n - 1; i >= 0; i--) begin
      fb = v[i] ^ crc_reg[14];
      serial_in_line = v[i];
      #16 link_clk = 1'b1;
      #16 link_clk = 1'b0;
      crc_reg = {crc_reg[13:0], 1'b0} ^ (fb ? CRC_POLY : 15'h0000);
    end
    serial_in_line = ~serial_in_line;
  endtask
  task automatic send_crc(input logic bad);
    logic [15:0] w;
    w = {crc_reg, 1'b0} ^ {bad, 15'h0000};
    send_raw({48'h0, w}, 16);
    crc_reg = CRC_SEED;
  endtask
  task automatic send_cmd(input logic [15:0] cmd, input logic bad);
    send_raw({48'h0, cmd}, 16);
    send_crc(bad);
  endtask
  task automatic start();
    chip_select_n = 1'b0;
    crc_reg = CRC_SEED;
    #16;
  endtask
  task automatic stop();
    chip_select_n = 1'b1;
    serial_in_line = ~serial_in_line;
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      serial_in_line = ~serial_in_line;
      #16 link_clk = 1'b1;
      #16 link_clk = 1'b0;
    end
  endtask
endmodule

// [pec_serial.sv]
// Purpose: Bit-serial 15-bit packet CRC generator.
// Assumes: One input bit per enabled clock edge, most significant bit first.
// Notes: Restart makes the seed the base for the current bit.
`timescale 1ns/1ps
module pec_serial (
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire logic                              en,
  input  wire logic                              restart,
  input  wire logic                              bit_in,
  output logic      [cmd_frame_pkg::CRC_W-1:0]   crc
);
  import cmd_frame_pkg::*;

  logic [CRC_W-1:0] crc_reg;
  logic [CRC_W-1:0] crc_next;
  wire  [CRC_W-1:0] base = restart ? CRC_SEED : crc_reg;
  wire              fb   = bit_in ^ base[CRC_W-1];

  assign crc_next = {base[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
  assign crc      = crc_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crc_reg <= CRC_SEED;
    end else if (en) begin
      crc_reg <= crc_next;
    end
  end
endmodule

// [tb_cmd_frame_and_conv_poll.sv]
// Purpose: Self-checking bench for the command frame and poll block.
// Assumes: Straps set to 4'ha, link clock 32 ns, system clock 5 ns.
// Notes: A monitor counts strobes; scenarios judge the change in counts.
`timescale 1ns/1ps
module tb_cmd_frame_and_conv_poll;
  import cmd_frame_pkg::*;
  localparam int NB = 6;
  logic            clk;
  logic            rst;
  logic            iface_mode_pin;
  logic            chain_variant_pin;
  logic            conv_busy;
  logic            addr_strap_bit3, addr_strap_bit2, addr_strap_bit1, addr_strap_bit0;
  logic            link_clk, chip_select_n, serial_in_line;
  logic            serial_out_line, pulse_reply, cmd_strobe, conv_start;
  logic            poll_active, block_ok;
  logic [OP_W-1:0] cmd_op_code;
  logic [8*NB-1:0] block_data;
  int              num_errors, comparisons, s0, c0, b0;
  int              strobes = 0;
  int              convs = 0;
  int              blocks = 0;

  cmd_frame_and_conv_poll #(.DBYTES(NB)) uut (
    .clk, .rst, .link_clk, .chip_select_n, .serial_in_line, .iface_mode_pin,
    .chain_variant_pin, .addr_strap_bit3, .addr_strap_bit2, .addr_strap_bit1,
    .addr_strap_bit0, .conv_busy, .serial_out_line, .pulse_reply, .cmd_strobe,
    .cmd_op_code, .conv_start, .poll_active, .block_ok, .block_data
  );
  host_link_model host (
    .link_clk(link_clk), .chip_select_n(chip_select_n), .serial_in_line(serial_in_line)
  );

  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (cmd_strobe === 1'b1) strobes++;
    if (conv_start === 1'b1) convs++;
    if (block_ok === 1'b1) blocks++;
  end

  task automatic check_val(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic set_busy(input logic v);
    @(posedge clk);
    conv_busy <= v;
    #1;
  endtask
  task automatic mark();
    s0 = strobes;
    c0 = convs;
    b0 = blocks;
  endtask
  function automatic logic [15:0] acmd(input logic [3:0] a, input logic [10:0] op);
    return {1'b1, a, op};
  endfunction
  task automatic frame(input logic [15:0] w, input logic bad);
    host.start();
    host.send_cmd(w, bad);
    tick(12);
  endtask
  task automatic end_frame();
    host.stop();
    tick(8);
  endtask

  task automatic t_reset();
    check_val(serial_out_line, 1'b1);
    check_val(poll_active, 1'b0);
    check_val(pulse_reply, 1'b0);
    check_val(cmd_op_code, 11'h000);
  endtask
  task automatic t_conv_hold();
    set_busy(1'b1);
    mark();
    frame({5'h00, 11'h360}, 1'b0);
    check_val(strobes - s0, 1);
    check_val(convs - c0, 1);
    check_val(cmd_op_code, 11'h360);
    check_val(serial_out_line, 1'b0);
    set_busy(1'b0);
    tick(2);
    check_val(serial_out_line, 1'b1);
    set_busy(1'b1);
    tick(2);
    check_val(serial_out_line, 1'b0);
    host.stop();
    #1;
    check_val(serial_out_line, 1'b1);
    tick(8);
    check_val(poll_active, 1'b0);
    set_busy(1'b0);
  endtask
  task automatic t_poll_addr();
    logic [10:0] ops [2];
    ops = '{OP_POLL, OP_DIAG};
    foreach (ops[i]) begin
      set_busy(1'b1);
      mark();
      frame(acmd(4'ha, ops[i]), 1'b0);
      check_val(strobes - s0, 1);
      check_val(convs - c0, 0);
      check_val(cmd_op_code, ops[i]);
      check_val(serial_out_line, 1'b0);
      set_busy(1'b0);
      tick(2);
      check_val(serial_out_line, 1'b1);
      end_frame();
    end
  endtask
  task automatic t_refused();
    set_busy(1'b1);
    mark();
    frame(acmd(4'h5, OP_POLL), 1'b0);
    check_val(poll_active, 1'b0);
    end_frame();
    host.start();
    host.send_raw(64'h5, 5);
    end_frame();
    frame({5'h00, OP_POLL}, 1'b1);
    host.pulses(8);
    check_val(serial_out_line, 1'b1);
    check_val(poll_active, 1'b0);
    end_frame();
    frame({5'h00, OP_POLL}, 1'b0);
    check_val(strobes - s0, 1);
    check_val(serial_out_line, 1'b0);
    end_frame();
    set_busy(1'b0);
  endtask
  task automatic frame_block(input logic [47:0] d, input logic bad);
    host.start();
    host.send_cmd({5'h00, 11'h001}, 1'b0);
    host.send_raw({16'h0, d}, 8 * NB);
    host.send_crc(bad);
    tick(12);
    end_frame();
  endtask
  task automatic t_block();
    logic [47:0] d;
    d = 48'h0123456789ab;
    mark();
    frame_block(d, 1'b0);
    check_val(blocks - b0, 1);
    check_val(block_data, d);
    frame_block(~d, 1'b1);
    check_val(blocks - b0, 1);
    check_val(block_data, d);
  endtask
  task automatic t_chain();
    @(posedge clk);
    chain_variant_pin <= 1'b1;
    set_busy(1'b1);
    tick(6);
    mark();
    frame({5'h00, 11'h360}, 1'b0);
    check_val(strobes - s0, 1);
    check_val(poll_active, 1'b0);
    check_val(serial_out_line, 1'b1);
    end_frame();
    set_busy(1'b0);
    tick(4);
    frame({5'h00, 11'h004}, 1'b0);
    check_val(strobes - s0, 2);
    check_val(convs - c0, 1);
    end_frame();
    frame(acmd(4'ha, OP_POLL), 1'b0);
    check_val(strobes - s0, 2);
    check_val(poll_active, 1'b0);
    end_frame();
    @(posedge clk);
    chain_variant_pin <= 1'b0;
    set_busy(1'b0);
    tick(6);
  endtask
  task automatic t_iso();
    @(posedge clk);
    iface_mode_pin <= 1'b1;
    set_busy(1'b1);
    tick(6);
    frame({5'h00, 11'h360}, 1'b0);
    host.pulses(4);
    check_val(pulse_reply, 1'b0);
    end_frame();
    frame(acmd(4'ha, OP_POLL), 1'b0);
    check_val(pulse_reply, 1'b0);
    check_val(serial_out_line, 1'b1);
    host.pulses(4);
    check_val(pulse_reply, 1'b1);
    set_busy(1'b0);
    tick(4);
    host.pulses(4);
    check_val(pulse_reply, 1'b0);
    set_busy(1'b1);
    tick(4);
    host.pulses(4);
    check_val(pulse_reply, 1'b1);
    end_frame();
    check_val(poll_active, 1'b0);
    check_val(pulse_reply, 1'b0);
    set_busy(1'b0);
    @(posedge clk);
    iface_mode_pin <= 1'b0;
    tick(6);
  endtask

  task automatic give_verdict();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    iface_mode_pin = 1'b0;
    chain_variant_pin = 1'b0;
    conv_busy = 1'b0;
    {addr_strap_bit3, addr_strap_bit2, addr_strap_bit1, addr_strap_bit0} = 4'ha;
    num_errors = 0;
    comparisons = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    tick(6);
    t_reset();
    t_conv_hold();
    t_poll_addr();
    t_refused();
    t_block();
    t_chain();
    t_iso();
    give_verdict();
  end
  // The tests need about 20 us; the watchdog allows a wide margin.
  initial begin
    #100000;
    num_errors++;
    give_verdict();
  end
endmodule
